/* File: hw/epft_core.sv */
`timescale 1ns/10ps
`include "epft_params.svh"
module epft_core
    import epft_pkg::*;
(
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        smp_valid,
    output logic             smp_ready,
    input  wire epft_smp_t   smp_data,
    input  wire logic [31:0] avg_act,
    input  wire logic [31:0] avg_react,
    output logic             res_valid,
    input  wire logic        res_ready,
    output epft_res_t        res_data,
    output logic [19:0]      period_q8,
    output logic [15:0]      freq_q8,
    output logic             freq_valid,
    output logic             act_pulse,
    output logic             react_pulse
);
    // tick in accumulator units
    localparam logic [47:0] TICK = `EPFT_KWH_EQUIV / `EPFT_PULSES_KWH;
    localparam logic [7:0]  PLEN = `EPFT_PULSE_LEN;

    // restoring division, used for interpolation and frequency
    function automatic logic [31:0] epft_div(
        input logic [31:0] num,
        input logic [23:0] den
    );
        logic [31:0] q;
        logic [24:0] r;
        q = '0;
        r = '0;
        for (int k = 31; k >= 0; k--) begin
            r = {r[23:0], num[k]};
            if (r >= {1'b0, den}) begin
                r = r - {1'b0, den};
                q[k] = 1'b1;
            end
        end
        return q;
    endfunction

    ////////////////////////////////////////////////////////////////////
    // input buffer: a stalled hand-off holds samples, none are lost
    epft_smp_t b_data;
    logic      b_vld, b_rdy, fire, hold_busy, handoff;

    epft_skid #(
        .W     ($bits(epft_smp_t)),
        .DEPTH (2)
    ) u_buf (
        .clk_sys   (clk_sys),
        .rst       (rst),
        .ce        (ce),
        .in_valid  (smp_valid),
        .in_ready  (smp_ready),
        .in_data   (smp_data),
        .out_valid (b_vld),
        .out_ready (b_rdy),
        .out_data  (b_data)
    );

    ////////////////////////////////////////////////////////////////////
    // zero crossing and period tracking on phase A
    epft_zc_t            zc_r, zc_nxt;
    logic signed [15:0]  vprev_r, vprev_nxt, cur;
    logic signed [16:0]  diff;
    logic        [11:0]  zcnt_r, zcnt_nxt;
    logic        [7:0]   frac_r, frac_nxt, frac;
    logic        [31:0]  fq;
    logic signed [21:0]  raw, filt;
    logic        [19:0]  per_r, per_nxt;
    logic        [15:0]  freq_r, freq_nxt;
    logic                rising, slew_ok, zc;

    assign cur     = $signed(b_data.v[0]);
    assign diff    = 17'(cur) - 17'(vprev_r);
    assign rising  = (vprev_r < 0) && (cur >= 0);
    // a spike flipping one sample jumps too far to be genuine
    assign slew_ok = diff <= $signed(`EPFT_MAX_SLEW);
    assign zc      = fire && rising && slew_ok;
    // fraction of a sample from previous sample to crossing
    assign fq   = epft_div({7'h00, 17'(-17'(vprev_r)), 8'h00},
                           {7'h00, diff});
    assign frac = (fq > 32'h000000ff) ? 8'hff : fq[7:0];
    assign raw  = 22'({zcnt_r, 8'h00}) + 22'(frac) - 22'(frac_r);
    // weak low-pass, 1/8 of the error per cycle
    // signed on both sides so a shorter cycle pulls the period down
    assign filt = $signed(22'(per_r)) +
                  ((raw - $signed(22'(per_r))) >>> `EPFT_LPF_SHIFT);

    always_comb begin
        zc_nxt    = zc_r;
        vprev_nxt = fire ? cur : vprev_r;
        zcnt_nxt  = zcnt_r;
        frac_nxt  = frac_r;
        per_nxt   = per_r;
        freq_nxt  = freq_r;
        if (fire) begin
            zcnt_nxt = (zcnt_r == 12'hfff) ? zcnt_r : zcnt_r + 12'h001;
        end
        if (zc) begin
            zcnt_nxt = 12'h001;
            frac_nxt = frac;
            case (zc_r)
                ZC_IDLE: begin
                    zc_nxt = ZC_FIRST;
                end
                ZC_FIRST: begin
                    zc_nxt  = ZC_TRACK;
                    per_nxt = raw[19:0];
                end
                ZC_TRACK: begin
                    per_nxt = filt[19:0];
                end
                default: begin
                    zc_nxt = ZC_IDLE;
                end
            endcase
            // hertz in q8 from samples per cycle in q8
            if (zc_r != ZC_IDLE && per_nxt != '0) begin
                freq_nxt = 16'(epft_div(`EPFT_FREQ_NUM,
                                        {4'h0, per_nxt}));
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            zc_r    <= ZC_IDLE;
            vprev_r <= '0;
            zcnt_r  <= '0;
            frac_r  <= '0;
            per_r   <= `EPFT_PER_INIT;
            freq_r  <= '0;
        end else if (ce) begin
            zc_r    <= zc_nxt;
            vprev_r <= vprev_nxt;
            zcnt_r  <= zcnt_nxt;
            frac_r  <= frac_nxt;
            per_r   <= per_nxt;
            freq_r  <= freq_nxt;
        end
    end

    assign period_q8  = per_r;
    assign freq_q8    = freq_r;
    assign freq_valid = (zc_r == ZC_TRACK) && (freq_r != '0);

    ////////////////////////////////////////////////////////////////////
    // accumulation, counters and hand-off
    epft_res_t   sum_r, sum_nxt, hold_r, hold_nxt, add;
    logic        rv_r, rv_nxt;

    // period due on a crossing after one second; forced if mains absent
    assign handoff = fire && ((zc && sum_r.smp_cnt >= `EPFT_SMP_RATE) ||
                     sum_r.smp_cnt >= `EPFT_SMP_MAX);
    // an untaken result stalls the sample stream at the hand-off
    assign hold_busy = rv_r && !res_ready;
    assign b_rdy = !(hold_busy && rising &&
                     sum_r.smp_cnt >= `EPFT_SMP_RATE) &&
                   !(hold_busy && sum_r.smp_cnt >= `EPFT_SMP_MAX);
    assign fire  = ce && b_vld && b_rdy;

    // this sample's contribution to every sum
    always_comb begin
        add = '0;
        for (int p = 0; p < 3; p++) begin
            add.vsq[p]   = 48'($signed(b_data.v[p]) *
                               $signed(b_data.v[p]));
            add.isq[p]   = 64'($signed(b_data.i[p]) *
                               $signed(b_data.i[p]));
            add.act[p]   = 64'($signed(b_data.v[p]) *
                               $signed(b_data.i[p]));
            add.react[p] = 64'($signed(b_data.v90[p]) *
                               $signed(b_data.i[p]));
        end
        add.smp_cnt = 16'h0001;
        add.cyc_cnt = zc ? 8'h01 : 8'h00;
    end

    always_comb begin
        sum_nxt  = sum_r;
        hold_nxt = hold_r;
        // set beats clear when a new period lands as the old is taken
        rv_nxt   = res_ready ? 1'b0 : rv_r;
        if (handoff) begin
            hold_nxt = sum_r;
            rv_nxt   = 1'b1;
            sum_nxt  = add;    // current sample opens the next period
        end else if (fire) begin
            for (int p = 0; p < 3; p++) begin
                sum_nxt.vsq[p]   = sum_r.vsq[p] + add.vsq[p];
                sum_nxt.isq[p]   = sum_r.isq[p] + add.isq[p];
                sum_nxt.act[p]   = sum_r.act[p] + add.act[p];
                sum_nxt.react[p] = sum_r.react[p] + add.react[p];
            end
            sum_nxt.smp_cnt = sum_r.smp_cnt + 16'h0001;
            sum_nxt.cyc_cnt = sum_r.cyc_cnt + add.cyc_cnt;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            sum_r  <= '0;
            hold_r <= '0;
            rv_r   <= 1'b0;
        end else if (ce) begin
            sum_r  <= sum_nxt;
            hold_r <= hold_nxt;
            rv_r   <= rv_nxt;
        end
    end

    assign res_valid = rv_r;
    assign res_data  = hold_r;

    ////////////////////////////////////////////////////////////////////
    // energy pulses: channel 0 active, channel 1 reactive
    logic [1:0][47:0] eacc_r, eacc_nxt, esum;
    logic [1:0][7:0]  pcnt_r, pcnt_nxt;
    logic [1:0]       pout_r, pout_nxt;

    // energy waits while a pulse is still running, so none is lost
    always_comb begin
        eacc_nxt = eacc_r;
        pcnt_nxt = pcnt_r;
        esum[0]  = eacc_r[0] + 48'(avg_act);
        esum[1]  = eacc_r[1] + 48'(avg_react);
        for (int c = 0; c < 2; c++) begin
            if (fire) begin
                eacc_nxt[c] = esum[c];
                if (pcnt_r[c] != 8'h00) begin
                    pcnt_nxt[c] = pcnt_r[c] - 8'h01;
                end else if (esum[c] >= TICK) begin
                    eacc_nxt[c] = esum[c] - TICK;
                    pcnt_nxt[c] = PLEN + 8'h01;
                end
            end
            pout_nxt[c] = pcnt_nxt[c] > 8'h01;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            eacc_r <= '0;
            pcnt_r <= '0;
            pout_r <= '0;
        end else if (ce) begin
            eacc_r <= eacc_nxt;
            pcnt_r <= pcnt_nxt;
            pout_r <= pout_nxt;
        end
    end

    assign act_pulse   = pout_r[0];
    assign react_pulse = pout_r[1];

    ////////////////////////////////////////////////////////////////////
    // checks
    a_vsum_add: assert property (
        @(posedge clk_sys) disable iff (rst)
        fire && !handoff |=>
        sum_r.vsq[0] == $past(sum_r.vsq[0]) + $past(add.vsq[0]))
        else $error("voltage sum did not add the sample");

    a_act_add: assert property (
        @(posedge clk_sys) disable iff (rst)
        fire && !handoff |=>
        sum_r.act[1] == $past(sum_r.act[1]) + $past(add.act[1]))
        else $error("active sum did not add the product");

    a_smp_count: assert property (
        @(posedge clk_sys) disable iff (rst)
        fire && !handoff |=> sum_r.smp_cnt == $past(sum_r.smp_cnt) + 1)
        else $error("sample count did not advance");

    a_hold_latch: assert property (
        @(posedge clk_sys) disable iff (rst)
        handoff |=> res_valid && sum_r.smp_cnt == 16'h0001 &&
        res_data.smp_cnt == $past(sum_r.smp_cnt))
        else $error("period not latched on hand-off");

    a_handoff_edge: assert property (
        @(posedge clk_sys) disable iff (rst)
        handoff |-> zc || sum_r.smp_cnt >= `EPFT_SMP_MAX)
        else $error("hand-off off a cycle boundary");

    a_zc_sign: assert property (
        @(posedge clk_sys) disable iff (rst)
        zc |-> vprev_r < 0 && cur >= 0 && frac <= 8'hff)
        else $error("crossing without a sign change");

    a_zc_slew: assert property (
        @(posedge clk_sys) disable iff (rst)
        fire && rising && diff > $signed(`EPFT_MAX_SLEW) |=>
        zcnt_r == $past(zcnt_r) + 1 || zcnt_r == 12'hfff)
        else $error("implausible step taken as crossing");

    a_energy_tick: assert property (
        @(posedge clk_sys) disable iff (rst)
        fire && pcnt_r[0] == 8'h00 && esum[0] >= TICK |=>
        eacc_r[0] == $past(esum[0]) - TICK && act_pulse)
        else $error("tick not subtracted or no pulse");

    a_pulse_gap: assert property (
        @(posedge clk_sys) disable iff (rst)
        $fell(act_pulse) |-> pcnt_r[0] == 8'h01)
        else $error("pulse ended with wrong count");
endmodule

/* File: hw/epft_params.svh */
`ifndef EPFT_PARAMS_SVH
`define EPFT_PARAMS_SVH
// conversion events per second, and forced hand-off without mains
`define EPFT_SMP_RATE   16'h1000
`define EPFT_SMP_MAX    16'h2000
// one kWh in 0.01 W x sample events, and pulses per kWh
`define EPFT_KWH_EQUIV  48'h015752a00000
`define EPFT_PULSES_KWH 48'h000000001900
// pulse high time in sample events
`define EPFT_PULSE_LEN  8'h14
// largest plausible step between samples around a crossing
`define EPFT_MAX_SLEW   17'h02ee0
// start value of the period, samples per cycle in q8
`define EPFT_PER_INIT   20'h051eb
`define EPFT_LPF_SHIFT  3
// sample rate shifted for a q8 result in hertz
`define EPFT_FREQ_NUM   32'h10000000
`endif

/* File: hw/epft_pkg.sv */
package epft_pkg;
    // one conversion event: three phases
    typedef struct packed {
        logic [2:0][15:0] v;
        logic [2:0][23:0] i;
        logic [2:0][15:0] v90;
    } epft_smp_t;
    // one accumulation period handed to the averaging stage
    typedef struct packed {
        logic [2:0][47:0] vsq;
        logic [2:0][63:0] isq;
        logic [2:0][63:0] act;
        logic [2:0][63:0] react;
        logic [15:0]      smp_cnt;
        logic [7:0]       cyc_cnt;
    } epft_res_t;
    typedef enum logic [1:0] {
        ZC_IDLE  = 2'b00,
        ZC_FIRST = 2'b01,
        ZC_TRACK = 2'b11
    } epft_zc_t;
endpackage

/* File: hw/epft_skid.sv */
`timescale 1ns/10ps
module epft_skid #(
    parameter int W     = 8,
    parameter int DEPTH = 2
) (
    input  wire logic         clk_sys,
    input  wire logic         rst,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [AW:0]   FULL = (AW+1)'(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);

    logic [W-1:0]  mem_r [DEPTH];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    // handshakes are combinational, storage is registered
    assign in_ready  = ce && (cnt_r != FULL);
    assign out_valid = ce && (cnt_r != '0);
    assign out_data  = mem_r[rp_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_comb begin
        wp_nxt  = push ? ((wp_r == LAST) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt  = pop ? ((rp_r == LAST) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // entries carry no reset; only the count says what is valid
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem_r[wp_r] <= in_data;
        end
    end

    a_skid_count: assert property (@(posedge clk_sys) disable iff (rst)
        cnt_r <= FULL) else $error("buffer count overflow");
endmodule

/* File: hw/epft_end.sv */
`timescale 1ns/10ps

/* File: bench/epft_src.sv */
`timescale 1ns/10ps
module epft_src
    import epft_pkg::*;
(
    input  wire logic clk_sys,
    input  wire logic rst,
    input  wire logic en,
    input  wire logic spike,
    input  wire logic smp_ready,
    output logic      smp_valid,
    output epft_smp_t smp_data
);
    int wave [80];
    int n;
    // one cycle of 80 samples; half-sample offset keeps zero off the grid
    initial begin
        smp_data = '0;
        for (int k = 0; k < 80; k++) begin
            wave[k] = $rtoi(10000.0 * $sin(6.2831853 * (k + 0.5) / 80.0));
        end
    end
    // phases share one wave, current is 4x voltage, v90 lags a quarter
    function automatic epft_smp_t mk(int k, bit flip);
        epft_smp_t s;
        for (int p = 0; p < 3; p++) begin
            s.v[p]   = 16'(flip ? -wave[k % 80] : wave[k % 80]);
            s.i[p]   = 24'(4 * wave[k % 80]);
            s.v90[p] = 16'(wave[(k + 60) % 80]);
        end
        return s;
    endfunction
    // offer held until taken; idle data inverts so stale words never match
    always @(posedge clk_sys) begin
        if (rst) begin
            smp_valid <= 1'b0;
            n         <= 0;
        end else if (!smp_valid || smp_ready) begin
            smp_valid <= en;
            smp_data  <= en ? mk(n, spike && n % 80 == 60) : ~smp_data;
            n         <= en ? n + 1 : n;
        end
    end
endmodule

/* File: bench/test_energy_pulse_freq_tracker.sv */
`timescale 1ns/10ps
module test_energy_pulse_freq_tracker;
    import epft_pkg::*;
    localparam longint TICK = 64'h15752a00000 / 6400;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        en = 1'b0;
    logic        spike = 1'b0;
    logic        res_ready = 1'b0;
    logic [31:0] avg_act = '0;
    logic [31:0] avg_react = '0;
    logic        smp_valid, smp_ready, res_valid, freq_valid;
    logic        act_pulse, react_pulse, a_q, r_q;
    epft_smp_t   smp_data;
    epft_res_t   res_data;
    logic [19:0] period_q8;
    logic [15:0] freq_q8;
    int          n_errors = 0, tests_run = 0, taken, np_a, np_r, run_a = 0;
    longint      svv, sii, svi, svr;
    logic [7:0]  cyc2;

    always #12.5 clk_sys = ~clk_sys;

    epft_core u_epft_core (.clk_sys(clk_sys), .rst(rst), .ce(ce),
        .smp_valid(smp_valid), .smp_ready(smp_ready), .smp_data(smp_data),
        .avg_act(avg_act), .avg_react(avg_react), .res_valid(res_valid),
        .res_ready(res_ready), .res_data(res_data), .period_q8(period_q8),
        .freq_q8(freq_q8), .freq_valid(freq_valid), .act_pulse(act_pulse),
        .react_pulse(react_pulse));
    epft_src u_epft_src (.clk_sys(clk_sys), .rst(rst), .en(en),
        .spike(spike), .smp_ready(smp_ready), .smp_valid(smp_valid),
        .smp_data(smp_data));

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(string nm, logic [63:0] seen, logic [63:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge clk_sys);
        rst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        taken = 0;
        np_a  = 0;
        np_r  = 0;
        rst <= 1'b0;
    endtask
    // bounded wait for a hand-off; running out ends the run
    task automatic wait_res();
        for (int k = 0; k < 6000 && res_valid !== 1'b1; k++) begin
            @(posedge clk_sys);
            #1;
        end
        if (res_valid !== 1'b1) begin
            n_errors++;
            final_report();
        end
    endtask
    // reference pulse count: counter loads 21, output high while above 1
    function automatic int npulse(longint avg, int n);
        longint acc = 0;
        int cnt = 0, np = 0;
        for (int s = 0; s < n; s++) begin
            if (cnt > 0) begin
                cnt--;
                acc += avg;
            end else if (acc + avg >= TICK) begin
                acc = acc + avg - TICK;
                cnt = 21;
                np++;
            end else
                acc += avg;
        end
        return np;
    endfunction
    task automatic pulse_round(logic [31:0] a, logic [31:0] r);
        do_reset();
        avg_act   <= a;
        avg_react <= r;
        en        <= 1'b1;
        for (int k = 0; k < 2000 && taken < 600; k++) @(posedge clk_sys);
        if (taken < 600) n_errors++;
        en <= 1'b0;
        repeat (5) @(posedge clk_sys);
        chk("act pulses", np_a, npulse(a, taken));
        chk("react pulses", np_r, npulse(r, taken));
        $display("pulse round done avg %0d %0d", a, r);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // count taken samples, pulse starts, and the length of each active pulse
    always @(posedge clk_sys) begin
        if (smp_valid && smp_ready) taken++;
        if (act_pulse && !a_q) np_a++;
        if (react_pulse && !r_q) np_r++;
        if (!act_pulse && a_q && !rst)
            chk("pulse width", run_a, 20);
        run_a = act_pulse ? run_a + 1 : 0;
        a_q = act_pulse;
        r_q = react_pulse;
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h6d77));
        do_reset();
        ce <= 1'b0;
        #1;
        chk("period init", period_q8, 20'h051eb);
        chk("pulse idle", {act_pulse, react_pulse, res_valid}, 0);
        @(posedge clk_sys);
        #1;
        chk("ready frozen", smp_ready, 0);
        @(posedge clk_sys);
        ce <= 1'b1;
        pulse_round(TICK, TICK - 1); // exact threshold versus one short
        repeat (2) pulse_round($urandom_range(TICK / 4, TICK / 20),
                               $urandom_range(TICK / 3, TICK / 30));
        // whole-cycle sums depend only on the cycle count, not the phase
        svv = 0; sii = 0; svi = 0; svr = 0;
        for (int k = 0; k < 80; k++) begin
            svv += u_epft_src.wave[k] * u_epft_src.wave[k];
            sii += 16 * u_epft_src.wave[k] * u_epft_src.wave[k];
            svi += 4 * u_epft_src.wave[k] * u_epft_src.wave[k];
            svr += 4 * u_epft_src.wave[(k + 60) % 80] * u_epft_src.wave[k];
        end
        do_reset();
        en <= 1'b1;
        wait_res();
        chk("first count", res_data.smp_cnt >= 4096 &&
            res_data.smp_cnt < 4176, 1);
        repeat (50) @(posedge clk_sys);
        #1;
        chk("result held", res_valid, 1);
        @(posedge clk_sys);
        res_ready <= 1'b1;
        @(posedge clk_sys);
        @(posedge clk_sys);
        res_ready <= 1'b0;
        #1;
        wait_res();
        chk("period count", res_data.smp_cnt, 4160);
        chk("cycle count", res_data.cyc_cnt >= 51 &&
            res_data.cyc_cnt <= 52, 1);
        chk("vsq sum", res_data.vsq[0], 52 * svv);
        chk("isq sum", res_data.isq[0], 52 * sii);
        chk("act sum", res_data.act[0], 52 * svi);
        chk("react sum", res_data.react[0], 52 * svr);
        cyc2 = res_data.cyc_cnt;
        @(posedge clk_sys);
        res_ready <= 1'b1;
        spike     <= 1'b1;
        repeat (100) @(posedge clk_sys);
        spike <= 1'b0;
        #1;
        wait_res();
        chk("spike count", res_data.smp_cnt, 4160);
        chk("spike cycles", res_data.cyc_cnt, cyc2);
        chk("period", period_q8 >= 20464 &&
            period_q8 <= 20496, 1);
        // 4096 samples per second over 80 per cycle is 51.2 Hz in q8
        chk("freq", freq_q8, 16'h3333);
        chk("freq valid", freq_valid, 1);
        $display("frequency and hand-off test done");
        final_report();
    end
endmodule
